// *** shared/adcc_pkg.sv ***
// Purpose: constants and types shared by the converter control block
// Assumes: 8-bit registers, one per aligned 32-bit APB word
// Notes: offsets are byte addresses
package adcc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0   = 8'h00;
	localparam logic [7:0] OFS_CTRL1   = 8'h04;
	localparam logic [7:0] OFS_CTRL2   = 8'h08;
	localparam logic [7:0] OFS_PINSEL  = 8'h0C;
	localparam logic [7:0] OFS_RES_LO  = 8'h10;
	localparam logic [7:0] OFS_RES_HI  = 8'h14;
	localparam logic [7:0] OFS_IRQ     = 8'h18;
	// conv_control_zero fields
	localparam int         C0_START    = 7;
	localparam int         C0_BUSY     = 6;
	localparam int         C0_ENABLE   = 5;
	localparam int         C0_FORMAT   = 4;
	localparam int         C0_CHAN_LSB = 0;
	// conv_control_one fields
	localparam int         C1_SRC_LSB  = 5;
	localparam int         C1_DIV_LSB  = 0;
	// conv_control_two fields
	localparam int         C2_AMP      = 7;
	localparam int         C2_BANDGAP  = 6;
	localparam int         C2_REF_LSB  = 0;
	// reset values
	localparam logic [7:0] CTRL0_RESET  = 8'h00;
	localparam logic [7:0] CTRL1_RESET  = 8'h00;
	localparam logic [7:0] CTRL2_RESET  = 8'h00;
	localparam logic [7:0] PINSEL_RESET = 8'h00;
	// converter model
	localparam int         RESULT_BITS = 12;
	localparam int         CONV_TICKS  = 16;
	localparam int         DIV_CNT_W   = 7;

	typedef enum logic [2:0] {
		SRC_EXT_A   = 3'b000,
		SRC_VDD     = 3'b001,
		SRC_VDD_2   = 3'b010,
		SRC_VDD_4   = 3'b011,
		SRC_EXT_B   = 3'b100
	} adcc_src_type;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_HOLD     = 2'b01,
		ST_CONVERT  = 2'b10
	} adcc_state_type;
endpackage

// *** hdl/adcc_clkdiv.sv ***
// Purpose: conversion clock tick generator, divide by 2 to the power of code
// Assumes: run low clears the prescaler
// Notes: tick is a one-cycle pulse, except at code zero where it stays high while run is high
`timescale 1ns/100ps
module adcc_clkdiv
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          run,
	input  wire logic [2:0]                    div_code,
	output logic                               tick
);
	logic [adcc_pkg::DIV_CNT_W-1:0] cnt_q;
	logic [adcc_pkg::DIV_CNT_W-1:0] limit;

	assign limit = (adcc_pkg::DIV_CNT_W)'((8'h01 << div_code) - 8'h01);
	assign tick  = run && (cnt_q == limit);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (!run || tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(run && div_code == 3'h0) |-> tick) else $error("undivided clock gave no tick");
	div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && div_code == 3'h1 && $stable(div_code)) ##1 (run && div_code == 3'h1) |-> !tick)
		else $error("divide by two ticked twice in a row");
endmodule // adcc_clkdiv

// *** hdl/adcc_mux.sv ***
// Purpose: input routing of external channels and scaled supply tap
// Assumes: samples are digital stand-ins for analog levels
// Notes: purely combinational
`timescale 1ns/100ps
module adcc_mux
(
	input  wire logic [2:0]                    src_sel,
	input  wire logic [1:0]                    chan_sel,
	input  wire logic [3:0][11:0]              ext_sample,
	input  wire logic [11:0]                   vdd_sample,
	output logic      [11:0]                   sample,
	output logic      [3:0]                    ext_connect
);
	always_comb
	begin
		sample      = 12'h000;
		ext_connect = 4'h0;
		case (src_sel)
			adcc_pkg::SRC_EXT_A, adcc_pkg::SRC_EXT_B:
			begin
				sample      = ext_sample[chan_sel];
				ext_connect = 4'h1 << chan_sel;
			end
			adcc_pkg::SRC_VDD:   sample = vdd_sample;
			adcc_pkg::SRC_VDD_2: sample = {1'b0, vdd_sample[11:1]};
			adcc_pkg::SRC_VDD_4: sample = {2'b00, vdd_sample[11:2]};
			// reserved codes convert zero with no pin attached
			default:             sample = 12'h000;
		endcase
	end
endmodule // adcc_mux

// *** hdl/adcc_top.sv ***
// Purpose: register file, start sequence and result formatting of the converter
// Assumes: APB slave, 32-bit data, one wait state on every transfer
// Notes:
// Functional notes
// - each conversion yields a twelve-bit result of the routed input
// - format zero: high byte holds bits 11..4, low byte top nibble bits 3..0
// - format one: high byte low nibble bits 11..8, low byte bits 7..0
// - unused result bit positions read as zero
// - converter disabled clears both result bytes and powers converter off
// - start written high then low begins conversion, busy set on the fall
// - start rising resets converter, clears busy, holds reset until low
// - busy is read-only and clears when the conversion completes
// - enable low means no conversion and converter switched off
// - two-bit channel field picks external input zero to three
// - source codes 000 and 100 route the selected external channel
// - source codes 001, 010, 011 route supply scaled by 1, 1/2, 1/4
// - internal source selected disconnects every external channel
// - clock field divides system clock by 1 to 128 in powers of two
// - analog pin select removes digital function and pull-high of the pin
// - unimplemented control bits read as zero
// - completion sets the converter interrupt request flag
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module adcc_top
#(
	parameter int                              CONV_TICKS = adcc_pkg::CONV_TICKS
)
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [3:0][11:0]              ext_sample,
	input  wire logic [11:0]                   vdd_sample,
	input  wire logic                          irq_flag_clear,
	output logic                               irq_flag,
	output logic                               converter_power,
	output logic                               converter_reset,
	output logic      [3:0]                    ext_connect,
	output logic      [7:0]                    pin_digital_off,
	output logic      [7:0]                    pin_pullup_off,
	output logic                               reference_amp_enable,
	output logic                               bandgap_enable,
	output logic      [3:0]                    reference_select
);
	// control registers
	logic                          start_q;
	logic                          enable_q;
	logic                          format_q;
	logic [1:0]                    chan_q;
	logic [2:0]                    src_q;
	logic [2:0]                    div_q;
	logic                          amp_q;
	logic                          bg_q;
	logic [3:0]                    ref_q;
	logic [7:0]                    pinsel_q;
	// conversion state
	adcc_pkg::adcc_state_type      state_q;
	logic                          busy_q;
	logic [11:0]                   sample_q;
	logic [11:0]                   result_q;
	logic [11:0]                   tick_cnt_q;
	logic                          irq_q;
	logic [3:0]                    ext_conn_q;
	// bus
	logic                          ack_q;
	logic [31:0]                   prdata_q;
	logic                          pslverr_q;
	logic                          access;
	logic                          wr;
	logic                          wr_ctrl0;
	logic                          start_d;
	logic                          en_d;
	logic                          rise;
	logic                          fall;
	logic                          tick;
	logic                          done;
	logic                          done_eff;
	logic [11:0]                   mux_sample;
	logic [3:0]                    mux_connect;
	logic [7:0]                    res_lo;
	logic [7:0]                    res_hi;
	logic [7:0]                    rd_byte;
	logic                          rd_hit;

	assign access   = psel && penable;
	assign pready   = ack_q;
	assign prdata   = prdata_q;
	assign pslverr  = pslverr_q;
	assign wr       = access && ack_q && pwrite;
	assign wr_ctrl0 = wr && (paddr == adcc_pkg::OFS_CTRL0);
	assign start_d  = wr_ctrl0 ? pwdata[adcc_pkg::C0_START] : start_q;
	assign en_d     = wr_ctrl0 ? pwdata[adcc_pkg::C0_ENABLE] : enable_q;
	assign rise     = start_d && !start_q;
	assign fall     = !start_d && start_q;

	adcc_clkdiv u_clkdiv
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (state_q == adcc_pkg::ST_CONVERT),
		.div_code (div_q),
		.tick     (tick)
	);

	adcc_mux u_mux
	(
		.src_sel     (src_q),
		.chan_sel    (chan_q),
		.ext_sample  (ext_sample),
		.vdd_sample  (vdd_sample),
		.sample      (mux_sample),
		.ext_connect (mux_connect)
	);

	assign done     = (state_q == adcc_pkg::ST_CONVERT) && tick
		&& (tick_cnt_q == 12'(CONV_TICKS - 1));
	assign done_eff = done && en_d && !rise && !fall;

	// apb answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ack_q <= 1'b0;
		else
			ack_q <= access && !ack_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			start_q  <= adcc_pkg::CTRL0_RESET[adcc_pkg::C0_START];
			enable_q <= adcc_pkg::CTRL0_RESET[adcc_pkg::C0_ENABLE];
			format_q <= adcc_pkg::CTRL0_RESET[adcc_pkg::C0_FORMAT];
			chan_q   <= adcc_pkg::CTRL0_RESET[adcc_pkg::C0_CHAN_LSB +: 2];
		end
		else if (wr_ctrl0)
		begin
			start_q  <= pwdata[adcc_pkg::C0_START];
			enable_q <= pwdata[adcc_pkg::C0_ENABLE];
			format_q <= pwdata[adcc_pkg::C0_FORMAT];
			chan_q   <= pwdata[adcc_pkg::C0_CHAN_LSB +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_q <= adcc_pkg::CTRL1_RESET[adcc_pkg::C1_SRC_LSB +: 3];
			div_q <= adcc_pkg::CTRL1_RESET[adcc_pkg::C1_DIV_LSB +: 3];
		end
		else if (wr && paddr == adcc_pkg::OFS_CTRL1)
		begin
			src_q <= pwdata[adcc_pkg::C1_SRC_LSB +: 3];
			div_q <= pwdata[adcc_pkg::C1_DIV_LSB +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			amp_q <= adcc_pkg::CTRL2_RESET[adcc_pkg::C2_AMP];
			bg_q  <= adcc_pkg::CTRL2_RESET[adcc_pkg::C2_BANDGAP];
			ref_q <= adcc_pkg::CTRL2_RESET[adcc_pkg::C2_REF_LSB +: 4];
		end
		else if (wr && paddr == adcc_pkg::OFS_CTRL2)
		begin
			amp_q <= pwdata[adcc_pkg::C2_AMP];
			bg_q  <= pwdata[adcc_pkg::C2_BANDGAP];
			ref_q <= pwdata[adcc_pkg::C2_REF_LSB +: 4];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pinsel_q <= adcc_pkg::PINSEL_RESET;
		else if (wr && paddr == adcc_pkg::OFS_PINSEL)
			pinsel_q <= pwdata[7:0];
	end

	// start sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= adcc_pkg::ST_IDLE;
		else if (!en_d)
			state_q <= adcc_pkg::ST_IDLE;
		else if (rise)
			state_q <= adcc_pkg::ST_HOLD;
		else if (fall)
			state_q <= adcc_pkg::ST_CONVERT;
		else
		begin
			case (state_q)
				adcc_pkg::ST_IDLE:    state_q <= adcc_pkg::ST_IDLE;
				adcc_pkg::ST_HOLD:    state_q <= adcc_pkg::ST_HOLD;
				adcc_pkg::ST_CONVERT: state_q <= done ? adcc_pkg::ST_IDLE : adcc_pkg::ST_CONVERT;
				default:              state_q <= adcc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_q <= 1'b0;
		else if (!en_d || rise)
			busy_q <= 1'b0;
		else if (fall)
			busy_q <= 1'b1;
		else if (done)
			busy_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= 12'h000;
		else if (state_q != adcc_pkg::ST_CONVERT || fall)
			tick_cnt_q <= 12'h000;
		else if (tick)
			tick_cnt_q <= tick_cnt_q + 12'h001;
	end

	// sample held at the start of conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sample_q <= 12'h000;
		else if (fall && en_d)
			sample_q <= mux_sample;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_q <= 12'h000;
		else if (!enable_q)
			result_q <= 12'h000;
		else if (done_eff)
			result_q <= sample_q;
	end

	// event set wins over an external clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else if (done_eff)
			irq_q <= 1'b1;
		else if (irq_flag_clear)
			irq_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_conn_q <= 4'h0;
		else
			ext_conn_q <= enable_q ? mux_connect : 4'h0;
	end

	assign res_lo = format_q ? result_q[7:0] : {result_q[3:0], 4'h0};
	assign res_hi = format_q ? {4'h0, result_q[11:8]} : result_q[11:4];

	always_comb
	begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		case (paddr)
			adcc_pkg::OFS_CTRL0:  rd_byte = {start_q, busy_q, enable_q, format_q, 2'b00, chan_q};
			adcc_pkg::OFS_CTRL1:  rd_byte = {src_q, 2'b00, div_q};
			adcc_pkg::OFS_CTRL2:  rd_byte = {amp_q, bg_q, 2'b00, ref_q};
			adcc_pkg::OFS_PINSEL: rd_byte = pinsel_q;
			adcc_pkg::OFS_RES_LO: rd_byte = res_lo;
			adcc_pkg::OFS_RES_HI: rd_byte = res_hi;
			adcc_pkg::OFS_IRQ:    rd_byte = {7'h00, irq_q};
			default:              rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (access && !ack_q)
		begin
			prdata_q  <= (rd_hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr_q <= !rd_hit;
		end
		else
			pslverr_q <= 1'b0;
	end

	assign irq_flag             = irq_q;
	assign converter_power      = enable_q;
	assign converter_reset      = !enable_q || (state_q == adcc_pkg::ST_HOLD);
	assign ext_connect          = ext_conn_q;
	assign pin_digital_off      = pinsel_q;
	assign pin_pullup_off       = pinsel_q;
	assign reference_amp_enable = amp_q;
	assign bandgap_enable       = bg_q;
	assign reference_select     = ref_q;

	fmt_zero_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !ack_q && !pwrite && paddr == adcc_pkg::OFS_RES_HI && !format_q)
		|=> prdata[7:0] == $past(result_q[11:4])) else $error("format zero high byte wrong");
	fmt_one_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !ack_q && !pwrite && paddr == adcc_pkg::OFS_RES_LO && format_q)
		|=> prdata[7:0] == $past(result_q[7:0])) else $error("format one low byte wrong");
	fmt_unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !ack_q && !pwrite && paddr == adcc_pkg::OFS_RES_HI && format_q)
		|=> prdata[7:4] == 4'h0) else $error("unused result bits not zero");
	disable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!enable_q && !en_d) |=> result_q == 12'h000 && !busy_q) else $error("disabled converter kept data");
	start_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
		(fall && en_d) |=> busy_q && state_q == adcc_pkg::ST_CONVERT) else $error("start fall did not start");
	start_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rise && en_d) |=> !busy_q && converter_reset) else $error("start rise did not reset");
	done_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_eff |=> !busy_q && irq_flag && result_q == $past(sample_q)) else $error("completion flags wrong");
	internal_iso_a: assert property (@(posedge pclk) disable iff (!presetn)
		(src_q != adcc_pkg::SRC_EXT_A && src_q != adcc_pkg::SRC_EXT_B) ##1 $stable(src_q)
		|-> ext_connect == 4'h0) else $error("external pin left connected");
	ctrl_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !ack_q && !pwrite && paddr == adcc_pkg::OFS_CTRL1)
		|=> prdata[4:3] == 2'b00) else $error("unimplemented bits not zero");
	result_atomic_a: assert property (@(posedge pclk) disable iff (!presetn)
		(enable_q && $past(enable_q) && result_q != $past(result_q)) |-> $past(done_eff))
		else $error("result changed outside completion");
endmodule // adcc_top

// *** verification/adcc_analog_model.sv ***
// Purpose: stand-in for the analog input pins and the supply tap of the converter
// Assumes: levels are fixed digital codes chosen by the bench, one per input
// Notes: the divided supply taps are formed inside the block, so only the full tap is given here
`timescale 1ns/100ps
module adcc_analog_model
#(
	parameter logic [3:0][11:0] EXT_LEVELS   = {12'hF61, 12'h09F, 12'hC3E, 12'h5A3},
	parameter logic [11:0]      SUPPLY_LEVEL = 12'hE6C
)
(
	output logic [3:0][11:0]    ext_sample,
	output logic [11:0]         vdd_sample
);
	// every external input differs from the others in every nibble so a wrong route or shift shows
	assign ext_sample = EXT_LEVELS;
	assign vdd_sample = SUPPLY_LEVEL;
endmodule // adcc_analog_model

// *** verification/tb.sv ***
// Purpose: self-checking bench of the converter control block over APB
// Assumes: CONV_TICKS reduced to 2 so every clock divider code runs quickly
// Notes: source codes 101..111 are never programmed
`timescale 1ns/100ps
module tb;
	localparam int              TICKS = 2;
	localparam logic [3:0][11:0] EXT  = {12'hF61, 12'h09F, 12'hC3E, 12'h5A3};
	localparam logic [11:0]     VDD   = 12'hE6C;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_flag_clear, irq_flag;
	logic [7:0] paddr, pin_digital_off, pin_pullup_off;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0][11:0] ext_sample;
	logic [11:0] vdd_sample;
	logic converter_power, converter_reset, reference_amp_enable, bandgap_enable, err;
	logic [3:0] ext_connect, reference_select;
	int num_errors, comparisons;

	adcc_analog_model #(.EXT_LEVELS(EXT), .SUPPLY_LEVEL(VDD)) i_adcc_analog_model
		(.ext_sample(ext_sample), .vdd_sample(vdd_sample));
	adcc_top #(.CONV_TICKS(TICKS)) i_adcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_sample(ext_sample), .vdd_sample(vdd_sample),
		.irq_flag_clear(irq_flag_clear), .irq_flag(irq_flag), .converter_power(converter_power),
		.converter_reset(converter_reset), .ext_connect(ext_connect), .pin_digital_off(pin_digital_off),
		.pin_pullup_off(pin_pullup_off), .reference_amp_enable(reference_amp_enable),
		.bandgap_enable(bandgap_enable), .reference_select(reference_select));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one APB transfer; an idle edge first so psel is never set twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk("pready timeout", 1, 0);
		// let the applied write settle before outputs are looked at
		@(negedge pclk);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, {24'h0, exp});
		chk("pslverr", err, 0);
	endtask

	task automatic wait_irq(output int cnt);
		cnt = 0;
		while (irq_flag !== 1'b1 && cnt < 2000)
		begin
			@(posedge pclk);
			cnt++;
		end
	endtask

	task automatic clear_irq();
		@(posedge pclk);
		irq_flag_clear <= 1'b1;
		@(posedge pclk);
		irq_flag_clear <= 1'b0;
		@(posedge pclk);
		chk("irq cleared", irq_flag, 0);
	endtask

	task automatic conv(input logic [2:0] src, input logic [1:0] ch, input logic fmt, input logic [2:0] dv);
		logic [11:0] d;
		logic [7:0] c0;
		logic ext;
		int cnt;
		ext = (src == 3'b000 || src == 3'b100);
		d = ext ? EXT[ch] : VDD >> (src - 3'd1);
		c0 = {3'b001, fmt, 2'b00, ch};
		clear_irq();
		apb(1'b1, adcc_pkg::OFS_CTRL1, {24'h0, src, 2'b11, dv});
		rchk("ctrl1", adcc_pkg::OFS_CTRL1, {src, 2'b00, dv});
		apb(1'b1, adcc_pkg::OFS_CTRL0, {24'h0, c0 | 8'h8C});
		chk("reset on rise", converter_reset, 1);
		apb(1'b1, adcc_pkg::OFS_CTRL0, {24'h0, c0});
		wait_irq(cnt);
		chk("duration low", cnt >= (TICKS - 1) * (1 << dv) + 1, 1);
		chk("duration high", cnt <= TICKS * (1 << dv) + 4, 1);
		chk("ext connect", ext_connect, ext ? 4'h1 << ch : 4'h0);
		rchk("busy done", adcc_pkg::OFS_CTRL0, c0);
		rchk("irq reg", adcc_pkg::OFS_IRQ, 8'h01);
		for (int f = 0; f < 2; f++)
		begin
			apb(1'b1, adcc_pkg::OFS_CTRL0, {24'h0, c0[7:5], f[0], c0[3:0]});
			rchk("res hi", adcc_pkg::OFS_RES_HI, f ? {4'h0, d[11:8]} : d[11:4]);
			rchk("res lo", adcc_pkg::OFS_RES_LO, f ? d[7:0] : {d[3:0], 4'h0});
		end
	endtask

	initial
	begin
		#80000;
		num_errors++;
		close_out();
	end

	initial
	begin
		int cnt;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		irq_flag_clear = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 8'h18; a += 4)
			rchk("reset value", a[7:0], 8'h00);
		chk("power at reset", converter_power, 0);
		apb(1'b1, 8'h1C, 32'hFF);
		chk("unmapped err", err, 1);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", err, 1);
		chk("unmapped data", rd, 0);
		apb(1'b1, adcc_pkg::OFS_PINSEL, 32'hA5);
		chk("digital off", pin_digital_off, 8'hA5);
		chk("pullup off", pin_pullup_off, 8'hA5);
		apb(1'b1, adcc_pkg::OFS_CTRL2, 32'hFF);
		rchk("ctrl2", adcc_pkg::OFS_CTRL2, 8'hCF);
		chk("ref outs", {reference_amp_enable, bandgap_enable, reference_select}, 6'h3F);
		for (int i = 0; i < 11; i++)
			conv(i < 4 ? 3'd0 : (i < 8 ? 3'd4 : i - 7), i % 4, i % 2, i % 8);
		// a second rise mid-conversion aborts it
		clear_irq();
		apb(1'b1, adcc_pkg::OFS_CTRL1, 32'h07);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'hA0);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h20);
		rchk("busy set", adcc_pkg::OFS_CTRL0, 8'h60);
		chk("powered", converter_power, 1);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'hA0);
		rchk("busy cleared", adcc_pkg::OFS_CTRL0, 8'hA0);
		repeat (300) @(posedge pclk);
		chk("no irq while held", irq_flag, 0);
		chk("held in reset", converter_reset, 1);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h20);
		wait_irq(cnt);
		chk("restart done", irq_flag, 1);
		// disable clears results and blocks conversions
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h00);
		rchk("hi cleared", adcc_pkg::OFS_RES_HI, 8'h00);
		rchk("lo cleared", adcc_pkg::OFS_RES_LO, 8'h00);
		chk("power off", converter_power, 0);
		clear_irq();
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h80);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h00);
		repeat (20) @(posedge pclk);
		rchk("no busy disabled", adcc_pkg::OFS_CTRL0, 8'h00);
		chk("no irq disabled", irq_flag, 0);
		apb(1'b1, adcc_pkg::OFS_RES_HI, 32'hFF);
		rchk("hi read only", adcc_pkg::OFS_RES_HI, 8'h00);
		apb(1'b1, adcc_pkg::OFS_CTRL0, 32'h40);
		rchk("busy read only", adcc_pkg::OFS_CTRL0, 8'h00);
		close_out();
	end
endmodule // tb
